// *** cbg_pkg.sv ***
// package: constants and carrier types for the processor card glue logic
package cbg_pkg;
   // core clock 250 MHz, period in ps
   localparam int CLK_PERIOD_PS = 4000;
   // power-on reset hold time in ms, converted to core cycles
   localparam int POR_HOLD_MS = 10;
   // cycles per ms first, so the product stays inside a 32-bit int
   localparam int POR_HOLD_CYC = POR_HOLD_MS * (1000000000 / CLK_PERIOD_PS);
   // master tick: 24MHz derived from 250MHz by a fractional accumulator
   localparam int MASTER_NUM = 24;
   localparam int MASTER_DEN = 250;
   localparam logic [8:0] ACC_RST = 9'h000;
   // first stage divides by three
   localparam logic [1:0] DIV3_LAST = 2'h2;
   localparam logic [1:0] DIV3_RST = 2'h0;
   localparam logic [2:0] STG2_RST = 3'h0;
   localparam logic [2:0] STG3_RST = 3'h0;
   // address decode values
   localparam logic [3:0] BLOCK0_HI = 4'h0;
   localparam logic [1:0] ADAPTOR_A10_9 = 2'h3;
   localparam logic [1:0] ROM_C000_HI = 2'h3;
   localparam logic [2:0] ROM_E000_HI = 3'h7;
   localparam logic [3:0] ROM_F000_HI = 4'hF;

   typedef enum logic [1:0]
   {
      CBG_CLK_1M = 2'h0,
      CBG_CLK_2M = 2'h1,
      CBG_CLK_3M = 2'h3
   } cbg_clk_sel_e;

   typedef enum logic [1:0]
   {
      CBG_RUN = 2'h0,
      CBG_HALT_PEND = 2'h1,
      CBG_HALT = 2'h3
   } cbg_dma_e;

   typedef struct packed
   {
      logic ram_sel_n;
      logic adaptor_sel_n;
      logic rom_c000_n;
      logic rom_e000_n;
      logic rom_f000_n;
      logic low_block_select_n;
   } cbg_dec_s;

   typedef struct packed
   {
      logic clk12;
      logic clk8;
      logic clk6;
      logic clk4;
      logic clk3;
      logic clk2;
      logic clk1;
   } cbg_clks_s;
endpackage

// *** cbg_sync.sv ***
// three-flop input synchroniser with agreement filter
`timescale 1ns/10ps
module cbg_sync #(
   parameter logic INIT = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } cbg_sync_s;

   cbg_sync_s st_r;
   cbg_sync_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // change counts once second and third stages agree
      if (st_r.s2 == st_r.s3)
      begin
         st_nxt.q = st_r.s3;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= {INIT, INIT, INIT, INIT};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.q;
endmodule

// *** cbg_clkdiv.sv ***
// master tick generation and the three-stage clock divider
`timescale 1ns/10ps
module cbg_clkdiv (
   input wire logic core_clk,
   input wire logic rst,
   output logic master_tick,
   output cbg_pkg::cbg_clks_s clks,
   output logic clk1_fall
);
   typedef struct packed
   {
      logic [8:0] acc;
      logic tick;
      logic [1:0] div3;
      logic [2:0] stg2;
      logic [2:0] stg3;
      logic fall;
   } cbg_div_s;

   cbg_div_s st_r;
   cbg_div_s st_nxt;
   logic en8;
   logic carry2;

   // stage one QA: high on the third master cycle
   assign en8 = (st_r.div3 == cbg_pkg::DIV3_LAST);
   // carry stays low until the count enable is high
   assign carry2 = en8 && (st_r.stg2 == 3'h7);

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.fall = 1'b0;
      if (st_r.acc >= 9'(cbg_pkg::MASTER_DEN - cbg_pkg::MASTER_NUM))
      begin
         st_nxt.acc = 9'(st_r.acc + cbg_pkg::MASTER_NUM - cbg_pkg::MASTER_DEN);
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.acc = 9'(st_r.acc + cbg_pkg::MASTER_NUM);
         st_nxt.tick = 1'b0;
      end
      if (st_r.tick)
      begin
         // clear every third master cycle
         if (en8)
         begin
            st_nxt.div3 = cbg_pkg::DIV3_RST;
         end
         else
         begin
            st_nxt.div3 = 2'(st_r.div3 + 2'h1);
         end
         if (en8)
         begin
            st_nxt.stg2 = 3'(st_r.stg2 + 3'h1);
         end
         // cleared by inverted carry, aligned to the 1MHz edge
         if (carry2)
         begin
            st_nxt.stg3 = cbg_pkg::STG3_RST;
            st_nxt.fall = 1'b1;
         end
         else
         begin
            st_nxt.stg3 = 3'(st_r.stg3 + 3'h1);
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= '{cbg_pkg::ACC_RST, 1'b0, cbg_pkg::DIV3_RST, cbg_pkg::STG2_RST,
                   cbg_pkg::STG3_RST, 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign master_tick = st_r.tick;
   assign clk1_fall = st_r.fall;
   // third stage bits give 12, 6 and 3 MHz; 24 ticks per clear keeps all in step
   assign clks = '{clk12: st_r.stg3[0], clk8: en8, clk6: st_r.stg3[1],
                   clk4: st_r.stg2[0], clk3: st_r.stg3[2], clk2: st_r.stg2[1],
                   clk1: st_r.stg2[2]};

   CVR_CLK1_FALL: cover property (@(posedge core_clk) disable iff (rst) st_r.fall);

   AST_DIV3_WRAP: assert property (@(posedge core_clk) disable iff (rst)
      st_r.tick && en8 |=> st_r.div3 == cbg_pkg::DIV3_RST)
      else $error("first stage did not clear on third cycle");
   AST_STG2_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      st_r.tick && !en8 |=> $stable(st_r.stg2))
      else $error("second stage advanced without enable");
   AST_STG3_CLR: assert property (@(posedge core_clk) disable iff (rst)
      st_r.tick && carry2 |=> st_r.stg3 == cbg_pkg::STG3_RST)
      else $error("third stage not cleared by carry");
   AST_CARRY_QUAL: assert property (@(posedge core_clk) disable iff (rst)
      !en8 |-> !carry2)
      else $error("carry high without count enable");
endmodule

// *** cbg_glue.sv ***
// top: processor card glue logic (reset, decode, clocks, wait, dma halt, strobes)
//
// Contract
// - hold active-low reset about 10 ms after power up, then release
// - block zero when address 15..12 all zero; drive low block indication
// - address 11 low selects RAM; full size covers 0000..07FF
// - half size RAM also needs address 10 low; 0000..03FF only
// - address 11, 10, 9 high in block zero selects adaptor, 0E00..0FFF
// - RAM or adaptor select inhibits backplane data buffer
// - three ROM selects: C000, E000, F000 upward; one routed to ROM
// - ROM select inhibits backplane buffer during processor reads
// - derive 12, 8, 6, 4, 3, 2, 1 MHz aligned to 1MHz falling edge
// - processor clock selectable as 1, 2 or 3 MHz through wait gating
// - first stage divides master by three, output enables next stage
// - second stage advances every third master cycle, gives 4, 2, 1 MHz
// - second stage carry stays low until its enable is high
// - slow access low forces processor clock high at next rising edge
// - slow access high again releases the wait and passes the clock
// - dma request high keeps ready high; same level drives grant
// - dma request low during read drops ready at next processor edge
// - while halted, address and direction and strobe drivers released
// - dma request high again raises ready at next processor edge
// - strobes only during phase two, read or write by direction
// - direction high for data into processor, low for data out
// - a halt requested during a write waits until the write ends
`timescale 1ns/10ps
module cbg_glue #(
   parameter int POR_CYC = cbg_pkg::POR_HOLD_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_dir,
   input wire logic cpu_phi2,
   input wire logic slow_access_ok,
   input wire logic dma_request_n,
   input wire logic clk_sel_fast,
   input wire logic clk_sel_slow,
   input wire logic clk_sel_mid,
   input wire logic ram_full_size_opt,
   input wire logic ram_half_size_opt,
   input wire logic [1:0] rom_map_header,
   output logic power_on_reset_n,
   output logic low_block_select_n,
   output logic ram_sel_n,
   output logic adaptor_sel_n,
   output logic [2:0] rom_range_n,
   output logic rom_sel_n,
   output logic buf_inhibit,
   output cbg_pkg::cbg_clks_s bus_clks,
   output logic cpu_clk,
   output logic cpu_ready,
   output logic halt_active,
   output logic dma_grant_n,
   output logic [15:0] addr_out,
   output logic addr_oe,
   output logic bus_dir,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic ctl_oe
);
   localparam int PW = $clog2(POR_CYC + 1);

   typedef struct packed
   {
      logic [PW-1:0] por_cnt;
      logic por_n;
      cbg_pkg::cbg_dec_s dec;
      logic [2:0] rom_rng;
      logic rom_sel;
      logic buf_inh;
      cbg_pkg::cbg_clks_s clks;
      logic sel_prev;
      logic wait_q;
      logic cpu_clk;
      cbg_pkg::cbg_dma_e dma;
      logic [15:0] addr;
      logic dir;
      logic rds_n;
      logic wds_n;
      logic oe;
      logic halt;
   } cbg_top_s;

   cbg_top_s st_r;
   cbg_top_s st_nxt;
   logic clk1_fall;
   cbg_pkg::cbg_clks_s clks;
   logic ready_s;
   logic dreq_s;
   logic sel_clk;
   logic sel_rise;
   logic in_block0;
   logic ram_hit;
   cbg_pkg::cbg_clk_sel_e clk_mode;

   cbg_sync #(.INIT(1'b1)) u_sync_ready (
      .core_clk(core_clk),
      .rst(rst),
      .din(slow_access_ok),
      .dout(ready_s)
   );

   // unconnected request reads as high through the pull-up
   cbg_sync #(.INIT(1'b1)) u_sync_dreq (
      .core_clk(core_clk),
      .rst(rst),
      .din(dma_request_n),
      .dout(dreq_s)
   );

   cbg_clkdiv u_div (
      .core_clk(core_clk),
      .rst(rst),
      .master_tick(),
      .clks(clks),
      .clk1_fall(clk1_fall)
   );

   always_comb
   begin
      if (clk_sel_fast)
      begin
         clk_mode = cbg_pkg::CBG_CLK_3M;
      end
      else if (clk_sel_mid)
      begin
         clk_mode = cbg_pkg::CBG_CLK_2M;
      end
      else
      begin
         clk_mode = cbg_pkg::CBG_CLK_1M;
      end
   end

   always_comb
   begin
      case (clk_mode)
         cbg_pkg::CBG_CLK_3M: sel_clk = clks.clk3;
         cbg_pkg::CBG_CLK_2M: sel_clk = clks.clk2;
         default: sel_clk = clks.clk1;
      endcase
   end

   assign sel_rise = sel_clk && !st_r.sel_prev;
   assign in_block0 = (cpu_addr[15:12] == cbg_pkg::BLOCK0_HI);
   // half size wins only when full size link absent
   assign ram_hit = in_block0 && !cpu_addr[11]
      && (ram_full_size_opt || !(ram_half_size_opt && cpu_addr[10]));

   always_comb
   begin
      st_nxt = st_r;
      // power-on reset counter
      if (!st_r.por_n)
      begin
         if (st_r.por_cnt == PW'(POR_CYC - 1))
         begin
            st_nxt.por_n = 1'b1;
         end
         else
         begin
            st_nxt.por_cnt = PW'(st_r.por_cnt + 1'b1);
         end
      end
      st_nxt.dec.low_block_select_n = !in_block0;
      st_nxt.dec.ram_sel_n = !ram_hit;
      st_nxt.dec.adaptor_sel_n = !(in_block0 && cpu_addr[11]
         && cpu_addr[10:9] == cbg_pkg::ADAPTOR_A10_9);
      st_nxt.rom_rng[0] = !(cpu_addr[15:14] == cbg_pkg::ROM_C000_HI);
      st_nxt.rom_rng[1] = !(cpu_addr[15:13] == cbg_pkg::ROM_E000_HI);
      st_nxt.rom_rng[2] = !(cpu_addr[15:12] == cbg_pkg::ROM_F000_HI);
      if (rom_map_header == 2'h0)
      begin
         st_nxt.rom_sel = st_nxt.rom_rng[0];
      end
      else if (rom_map_header == 2'h1)
      begin
         st_nxt.rom_sel = st_nxt.rom_rng[1];
      end
      else
      begin
         st_nxt.rom_sel = st_nxt.rom_rng[2];
      end
      st_nxt.buf_inh = !st_nxt.dec.ram_sel_n || !st_nxt.dec.adaptor_sel_n
         || (!st_nxt.rom_sel && cpu_dir);
      // every divided clock registered each cycle; counters share one reset
      st_nxt.clks = clks;
      // wait gating: capture on rising edge of selected clock
      st_nxt.sel_prev = sel_clk;
      if (!ready_s && sel_rise)
      begin
         st_nxt.wait_q = 1'b1;
      end
      else if (ready_s)
      begin
         st_nxt.wait_q = 1'b0;
      end
      st_nxt.cpu_clk = sel_clk || st_nxt.wait_q;
      // dma halt handshake on rising processor clock
      case (st_r.dma)
         cbg_pkg::CBG_RUN:
         begin
            if (!dreq_s)
            begin
               st_nxt.dma = cbg_pkg::CBG_HALT_PEND;
            end
         end
         cbg_pkg::CBG_HALT_PEND:
         begin
            if (dreq_s)
            begin
               st_nxt.dma = cbg_pkg::CBG_RUN;
            end
            else if (sel_rise && !st_r.wait_q && cpu_dir)
            begin
               st_nxt.dma = cbg_pkg::CBG_HALT;
            end
         end
         cbg_pkg::CBG_HALT:
         begin
            if (dreq_s && sel_rise && !st_r.wait_q)
            begin
               st_nxt.dma = cbg_pkg::CBG_RUN;
            end
         end
         default: st_nxt.dma = cbg_pkg::CBG_RUN;
      endcase
      st_nxt.oe = (st_nxt.dma != cbg_pkg::CBG_HALT);
      st_nxt.halt = (st_nxt.dma == cbg_pkg::CBG_HALT);
      st_nxt.addr = cpu_addr;
      st_nxt.dir = cpu_dir;
      st_nxt.rds_n = !(cpu_phi2 && cpu_dir);
      st_nxt.wds_n = !(cpu_phi2 && !cpu_dir);
   end

   // all state in core clock domain
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= '{por_cnt: '0, por_n: 1'b0, dec: '1, rom_rng: 3'h7, rom_sel: 1'b1,
                   buf_inh: 1'b0, clks: '0, sel_prev: 1'b0, wait_q: 1'b0,
                   cpu_clk: 1'b0, dma: cbg_pkg::CBG_RUN, addr: 16'h0000,
                   dir: 1'b1, rds_n: 1'b1, wds_n: 1'b1, oe: 1'b1, halt: 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign power_on_reset_n = st_r.por_n;
   assign low_block_select_n = st_r.dec.low_block_select_n;
   assign ram_sel_n = st_r.dec.ram_sel_n;
   assign adaptor_sel_n = st_r.dec.adaptor_sel_n;
   assign rom_range_n = st_r.rom_rng;
   assign rom_sel_n = st_r.rom_sel;
   assign buf_inhibit = st_r.buf_inh;
   assign bus_clks = st_r.clks;
   assign cpu_clk = st_r.cpu_clk;
   assign cpu_ready = st_r.oe;
   assign halt_active = st_r.halt;
   assign dma_grant_n = st_r.oe;
   assign addr_out = st_r.addr;
   assign addr_oe = st_r.oe;
   assign bus_dir = st_r.dir;
   assign read_strobe_n = st_r.rds_n;
   assign write_strobe_n = st_r.wds_n;
   assign ctl_oe = st_r.oe;

   AST_POR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      $rose(power_on_reset_n) |-> st_r.por_cnt == PW'(POR_CYC - 1))
      else $error("reset released at wrong count");
   AST_BLOCK0: assert property (@(posedge core_clk) disable iff (rst)
      cpu_addr[15:12] == 4'h0 |=> !low_block_select_n)
      else $error("block zero not indicated");
   AST_RAM_HALF: assert property (@(posedge core_clk) disable iff (rst)
      !ram_full_size_opt && ram_half_size_opt && cpu_addr[15:10] == 6'h01 |=> ram_sel_n)
      else $error("half size ram answered upper kilobyte");
   AST_ADAPTOR: assert property (@(posedge core_clk) disable iff (rst)
      cpu_addr[15:9] == 7'h07 |=> !adaptor_sel_n && buf_inhibit)
      else $error("adaptor select or inhibit missing");
   AST_ROM_F000: assert property (@(posedge core_clk) disable iff (rst)
      cpu_addr[15:12] == 4'hF |=> rom_range_n == 3'h0)
      else $error("rom ranges wrong at top page");
   AST_WAIT_HIGH: assert property (@(posedge core_clk) disable iff (rst)
      st_r.wait_q && !ready_s |=> cpu_clk)
      else $error("processor clock not held high during wait");
   AST_HALT_NO_WRITE: assert property (@(posedge core_clk) disable iff (rst)
      st_r.dma == cbg_pkg::CBG_HALT_PEND && !cpu_dir |=> !halt_active)
      else $error("halt entered during write");
   AST_HALT_RELEASE: assert property (@(posedge core_clk) disable iff (rst)
      halt_active |-> !addr_oe && !ctl_oe && !dma_grant_n)
      else $error("drivers enabled while halted");
   AST_STROBES: assert property (@(posedge core_clk) disable iff (rst)
      !cpu_phi2 |=> read_strobe_n && write_strobe_n)
      else $error("strobe outside phase two");
   AST_CLK_ALIGN: assert property (@(posedge core_clk) disable iff (rst)
      clk1_fall |=> bus_clks == '0)
      else $error("divided clocks not aligned to 1MHz fall");

   CVR_WAIT: cover property (@(posedge core_clk) disable iff (rst) $rose(st_r.wait_q));
   CVR_HALT: cover property (@(posedge core_clk) disable iff (rst) $rose(halt_active));
   CVR_UNHALT: cover property (@(posedge core_clk) disable iff (rst) $fell(halt_active));
endmodule

// *** cbg_backplane.sv ***
// backplane partner: slow peripheral wait line and dma master request
`timescale 1ns/10ps
module cbg_backplane (
   input wire logic core_clk,
   input wire logic wait_cmd,
   input wire logic dma_cmd,
   output logic slow_access_ok,
   output logic dma_request_n
);
   // lines rest high while no command pulls them, as with the pull-ups
   always @(posedge core_clk)
   begin
      slow_access_ok <= !wait_cmd;
      dma_request_n <= !dma_cmd;
   end
endmodule

// *** test_cbg_glue.sv ***
// self-checking bench for the processor card glue logic
`timescale 1ns/10ps
module test_cbg_glue;
   localparam int POR = 20;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] cpu_addr = 16'h1000;
   logic cpu_dir = 1'b1;
   logic cpu_phi2 = 1'b0;
   logic [2:0] sel = 3'b001;
   logic ram_full = 1'b1;
   logic [1:0] rom_hdr = 2'h0;
   logic wait_cmd = 1'b0;
   logic dma_cmd = 1'b0;
   logic slow_access_ok;
   logic dma_request_n;
   logic power_on_reset_n;
   logic low_block_select_n;
   logic ram_sel_n;
   logic adaptor_sel_n;
   logic [2:0] rom_range_n;
   logic rom_sel_n;
   logic buf_inhibit;
   cbg_pkg::cbg_clks_s bus_clks;
   logic cpu_clk;
   logic cpu_ready;
   logic halt_active;
   logic dma_grant_n;
   logic [15:0] addr_out;
   logic addr_oe;
   logic bus_dir;
   logic read_strobe_n;
   logic write_strobe_n;
   logic ctl_oe;
   int err_count = 0;
   int tests_run = 0;
   int n;
   int exp_r[7] = '{4, 8, 12, 16, 24, 32, 48};

   always #2 core_clk = !core_clk;

   cbg_backplane u_cbg_backplane (.core_clk(core_clk), .wait_cmd(wait_cmd), .dma_cmd(dma_cmd),
      .slow_access_ok(slow_access_ok), .dma_request_n(dma_request_n));

   cbg_glue #(.POR_CYC(POR)) u_cbg_glue (.core_clk(core_clk), .rst(rst), .cpu_addr(cpu_addr),
      .cpu_dir(cpu_dir), .cpu_phi2(cpu_phi2), .slow_access_ok(slow_access_ok),
      .dma_request_n(dma_request_n), .clk_sel_fast(sel[2]), .clk_sel_slow(sel[0]),
      .clk_sel_mid(sel[1]), .ram_full_size_opt(ram_full), .ram_half_size_opt(!ram_full),
      .rom_map_header(rom_hdr), .power_on_reset_n(power_on_reset_n),
      .low_block_select_n(low_block_select_n), .ram_sel_n(ram_sel_n),
      .adaptor_sel_n(adaptor_sel_n), .rom_range_n(rom_range_n), .rom_sel_n(rom_sel_n),
      .buf_inhibit(buf_inhibit), .bus_clks(bus_clks), .cpu_clk(cpu_clk),
      .cpu_ready(cpu_ready), .halt_active(halt_active), .dma_grant_n(dma_grant_n),
      .addr_out(addr_out), .addr_oe(addr_oe), .bus_dir(bus_dir), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .ctl_oe(ctl_oe));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask

   // exp holds block, ram, adaptor and three rom range selects
   task automatic dec(input logic [15:0] a, input logic [5:0] exp);
      logic rs;
      @(posedge core_clk);
      cpu_addr <= a;
      tick(3);
      rs = exp[(rom_hdr > 2'h1) ? 2 : rom_hdr];
      chk({low_block_select_n, ram_sel_n, adaptor_sel_n, rom_range_n, rom_sel_n, buf_inhibit},
         {exp, rs, !exp[4] || !exp[3] || !rs});
      chk(addr_out, a);
   endtask

   function automatic logic sig(input int i);
      return (i == 7) ? cpu_clk : bus_clks[i];
   endfunction

   // rising edges over 4 us, counted from a 1 MHz falling edge
   task automatic rises(input int i, output int r);
      logic p;
      r = 0;
      @(negedge bus_clks.clk1);
      tick(1);
      p = sig(i);
      repeat (1000)
      begin
         tick(1);
         if (sig(i) && !p)
            r++;
         p = sig(i);
      end
   endtask

   task automatic wait_halt(input logic lvl);
      for (int k = 0; k < 600 && halt_active !== lvl; k++)
         tick(1);
   endtask

   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      #120000;
      err_count++;
      stop_test();
   end

   initial
   begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      tick(2);
      chk(power_on_reset_n, 1'b0);
      tick(POR + 10);
      chk(power_on_reset_n, 1'b1);
      chk({halt_active, dma_grant_n, cpu_ready, addr_oe, ctl_oe}, 5'h0F);
      dec(16'h0000, 6'b001111);
      dec(16'h07FF, 6'b001111);
      dec(16'h0800, 6'b011111);
      dec(16'h0E00, 6'b010111);
      dec(16'h0FFF, 6'b010111);
      dec(16'h1000, 6'b111111);
      dec(16'hBFFF, 6'b111111);
      for (int h = 0; h < 4; h++)
      begin
         @(posedge core_clk);
         rom_hdr <= h[1:0];
         dec(16'hC000, 6'b111110);
         dec(16'hE000, 6'b111100);
         dec(16'hF000, 6'b111000);
      end
      @(posedge core_clk);
      ram_full <= 1'b0;
      dec(16'h03FF, 6'b001111);
      dec(16'h0400, 6'b011111);
      dec(16'h1000, 6'b111111);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge core_clk);
         cpu_phi2 <= i[1];
         cpu_dir <= i[0];
         tick(3);
         chk({bus_dir, read_strobe_n, write_strobe_n}, {i[0], !(i[1] && i[0]),
            !(i[1] && !i[0])});
      end
      for (int i = 0; i < 7; i++)
      begin
         rises(i, n);
         chk(16'(n), 16'(exp_r[i]));
      end
      for (int i = 2; i >= 0; i--)
      begin
         @(posedge core_clk);
         sel <= 3'b001 << i;
         rises(7, n);
         chk(16'(n), 16'(4 * (i + 1)));
      end
      @(posedge core_clk);
      wait_cmd <= 1'b1;
      rises(7, n);
      chk(16'(n), 16'h0000);
      chk(cpu_clk, 1'b1);
      @(posedge core_clk);
      wait_cmd <= 1'b0;
      rises(7, n);
      chk(16'(n), 16'h0004);
      @(posedge core_clk);
      cpu_dir <= 1'b1;
      dma_cmd <= 1'b1;
      wait_halt(1'b1);
      chk({halt_active, dma_grant_n, cpu_ready, addr_oe, ctl_oe}, 5'h10);
      @(posedge core_clk);
      dma_cmd <= 1'b0;
      wait_halt(1'b0);
      chk({halt_active, dma_grant_n, cpu_ready, addr_oe, ctl_oe}, 5'h0F);
      @(posedge core_clk);
      cpu_dir <= 1'b0;
      dma_cmd <= 1'b1;
      tick(600);
      chk(halt_active, 1'b0);
      @(posedge core_clk);
      cpu_dir <= 1'b1;
      wait_halt(1'b1);
      chk({halt_active, dma_grant_n, addr_oe}, 3'h4);
      @(posedge core_clk);
      dma_cmd <= 1'b0;
      wait_halt(1'b0);
      chk(cpu_ready, 1'b1);
      stop_test();
   end
endmodule
